//--- rtl/fpc_pkg.sv
// package for the fast ethernet pcs control, status and counter bank
// assumes one 125 MHz clock domain and a serial management link
package fpc_pkg;
    // register addresses on the management link
    localparam logic [4:0]  REG_BYPASS_CTRL  = 5'h10;
    localparam logic [4:0]  REG_STATUS_FLAGS = 5'h11;
    localparam logic [4:0]  REG_RXERR_COUNT  = 5'h12;
    localparam logic [4:0]  REG_FCAR_FIFO    = 5'h13;
    // control bit positions
    localparam int          BIT_BYP_4B5B     = 10;
    localparam int          BIT_BYP_SCRAM    = 9;
    localparam int          BIT_BYP_NRZI     = 8;
    localparam int          BIT_BYP_ALIGN    = 7;
    localparam int          BIT_BW_DISABLE   = 6;
    localparam int          BIT_FEF_ENABLE   = 5;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] CTRL_WMASK       = 16'h07e0;
    // latched flag indices, bit 0 upward
    localparam int          NUM_FLAGS        = 6;
    localparam logic [5:0]  FLAGS_RESET      = 6'h00;
    // counters: index 0 receive errors, 1 false carrier, 2 fifo overrun
    localparam int          NUM_CNT          = 3;
    localparam int          CNT_RXERR        = 0;
    localparam int          CNT_FCAR         = 1;
    localparam int          CNT_XRUN         = 2;
    localparam logic [15:0] RXERR_MAX        = 16'h00ff;
    localparam logic [15:0] BYTE_MAX         = 16'h00ff;
    localparam logic [15:0] CNT_RESET        = 16'h0000;
    // management frame layout
    localparam logic [5:0]  PRE_LEN          = 6'h20;
    localparam logic [4:0]  HDR_LAST         = 5'h0c;
    localparam logic [4:0]  TA_DRIVE         = 5'h01;
    localparam logic [4:0]  DATA_FIRST       = 5'h02;
    localparam logic [4:0]  DATA_LAST        = 5'h11;
    localparam logic [4:0]  RD_RELEASE       = 5'h12;
    localparam logic [1:0]  OP_READ          = 2'h2;
    localparam logic [1:0]  OP_WRITE         = 2'h1;
    typedef enum logic [1:0] {
        ST_PRE = 2'h0,
        ST_HDR = 2'h1,
        ST_RD  = 2'h3,
        ST_WR  = 2'h2
    } fpc_mgmt_state_t;
endpackage

//--- rtl/fpc_cnt_if.sv
// carrier between the register bank and one saturating counter
// assumes both ends on the same clock
`timescale 1ns/100ps
interface fpc_cnt_if;
    logic        inc;
    logic        clr;
    logic [15:0] value;
    modport cnt (input inc, input clr, output value);
    modport ctl (output inc, output clr, input value);
endinterface

//--- rtl/fpc_sat_counter.sv
// saturating clear-on-read event counter
// assumes clr is a single-cycle pulse on mclk_i; inc counts once per cycle it is high
`timescale 1ns/100ps
module fpc_sat_counter
    import fpc_pkg::*;
#(
    parameter logic [15:0] MAX = BYTE_MAX
) (
    input  wire logic mclk_i,
    input  wire logic reset_i,
    fpc_cnt_if.cnt    port
);
    logic [15:0] count;
    logic [15:0] next_count;
    wire         at_max = (count == MAX);

    // clear wins over the old value, but a same-cycle event still counts
    assign next_count = port.clr ? (port.inc ? 16'h0001 : CNT_RESET) :
                        (port.inc && !at_max) ? 16'(count + 16'h0001) : count;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            count <= CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    assign port.value = count;

    property p_cnt_sat;
        @(posedge mclk_i) disable iff (reset_i)
        (at_max && !port.clr) |=> (count == MAX);
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter left its maximum");

    property p_cnt_clr;
        @(posedge mclk_i) disable iff (reset_i)
        (port.clr && !port.inc) |=> (count == CNT_RESET);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared by read");

    property p_cnt_inc;
        @(posedge mclk_i) disable iff (reset_i)
        (port.inc && !port.clr && !at_max) |=> (count == $past(count) + 16'h0001);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed an event");

    c_cnt_full: cover property (@(posedge mclk_i) disable iff (reset_i) at_max && port.inc);
endmodule

//--- rtl/fpc_top.sv
// pcs bypass control, live and latched status, error counters
// assumes serial management pins from outside, pcs events on mclk_i
`timescale 1ns/100ps
module fpc_top
    import fpc_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    input  wire logic [4:0] phy_addr_i,
    input  wire logic       signal_detect_pair_p_i,
    input  wire logic       signal_detect_pair_n_i,
    input  wire logic       fifo_error_i,
    input  wire logic       locked_i,
    input  wire logic       link_pass_i,
    input  wire logic       remote_fault_i,
    input  wire logic       false_carrier_i,
    input  wire logic       end_of_stream_delimiter_err_i,
    input  wire logic       rx_code_err_i,
    input  wire logic       tx_code_err_i,
    input  wire logic       lock_err_i,
    input  wire logic       mlt3_err_i,
    input  wire logic       rx_err_packet_i,
    input  wire logic       fifo_xrun_i,
    output logic            bypass_4b5b_o,
    output logic            bypass_scrambler_o,
    output logic            bypass_nrzi_o,
    output logic            bypass_align_o,
    output logic            bw_corr_disable_o,
    output logic            far_end_fault_enable_o
);
    // pin synchronisers
    logic       mdc_s1, mdc_s2, mdc_s3;
    logic       mdio_s1, mdio_s2;
    logic       sdp_s1, sdp_s2, sdn_s1, sdn_s2;
    logic [4:0] phy_s1, phy_s2;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mdc_s1  <= 1'b0;
            mdc_s2  <= 1'b0;
            mdc_s3  <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
            sdp_s1  <= 1'b0;
            sdp_s2  <= 1'b0;
            sdn_s1  <= 1'b0;
            sdn_s2  <= 1'b0;
            phy_s1  <= 5'h00;
            phy_s2  <= 5'h00;
        end else begin
            mdc_s1  <= mdc_i;
            mdc_s2  <= mdc_s1;
            mdc_s3  <= mdc_s2;
            mdio_s1 <= mdio_i;
            mdio_s2 <= mdio_s1;
            sdp_s1  <= signal_detect_pair_p_i;
            sdp_s2  <= sdp_s1;
            sdn_s1  <= signal_detect_pair_n_i;
            sdn_s2  <= sdn_s1;
            phy_s1  <= phy_addr_i;
            phy_s2  <= phy_s1;
        end
    end

    wire mdc_rise = mdc_s2 && !mdc_s3;
    wire mdc_fall = !mdc_s2 && mdc_s3;

    // management frame engine
    fpc_mgmt_state_t state;
    logic [5:0]      ones;
    logic [4:0]      bitcnt;
    logic [12:0]     hdr;
    logic [15:0]     rd_shift;
    logic [15:0]     wr_shift;
    logic [15:0]     ctrl;
    logic [15:0]     read_word;
    logic [15:0]     status_word;

    wire [12:0] hdr_next   = {hdr[11:0], mdio_s2};
    wire [1:0]  hdr_op     = hdr_next[11:10];
    wire [4:0]  hdr_reg    = hdr_next[4:0];
    wire        hdr_ok     = hdr_next[12] && (hdr_next[9:5] == phy_s2);
    wire        reg_hit    = (hdr_reg[4:2] == REG_BYPASS_CTRL[4:2]);
    wire        hdr_done   = mdc_rise && (state == ST_HDR) && (bitcnt == HDR_LAST);
    wire        rd_start   = hdr_done && hdr_ok && reg_hit && (hdr_op == OP_READ);
    wire        wr_start   = hdr_done && hdr_ok && reg_hit && (hdr_op == OP_WRITE);
    wire        wr_fire    = mdc_rise && (state == ST_WR) && (bitcnt == DATA_LAST);
    wire [15:0] wr_word    = {wr_shift[14:0], mdio_s2};
    wire        pre_start  = mdc_rise && (state == ST_PRE) && !mdio_s2 && (ones >= PRE_LEN);
    wire        rd_release = mdc_fall && (state == ST_RD) && (bitcnt == RD_RELEASE);

    // read clears the latched flags and the addressed counters
    wire        rd_status  = rd_start && (hdr_reg == REG_STATUS_FLAGS);
    wire        rd_rxerr   = rd_start && (hdr_reg == REG_RXERR_COUNT);
    wire        rd_fcar    = rd_start && (hdr_reg == REG_FCAR_FIFO);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state  <= ST_PRE;
            ones   <= 6'h00;
            bitcnt <= 5'h00;
            hdr    <= 13'h0000;
        end else if (pre_start) begin
            state  <= ST_HDR;
            bitcnt <= 5'h00;
            ones   <= 6'h00;
        end else if (mdc_rise && state == ST_PRE) begin
            ones   <= !mdio_s2 ? 6'h00 : (ones == PRE_LEN) ? ones : 6'(ones + 6'h01);
        end else if (mdc_rise && state == ST_HDR) begin
            hdr    <= hdr_next;
            bitcnt <= (bitcnt == HDR_LAST) ? 5'h00 : 5'(bitcnt + 5'h01);
            state  <= rd_start ? ST_RD : wr_start ? ST_WR : (hdr_done ? ST_PRE : ST_HDR);
        end else if (wr_fire || rd_release) begin
            state  <= ST_PRE;
            bitcnt <= 5'h00;
        end else if (mdc_rise && (state == ST_RD || state == ST_WR)) begin
            bitcnt <= 5'(bitcnt + 5'h01);
        end
    end

    // turnaround then data, msb first, changed on falling mdc
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mdio_o    <= 1'b0;
            mdio_oe_o <= 1'b0;
            rd_shift  <= 16'h0000;
        end else if (rd_start) begin
            rd_shift  <= read_word;
        end else if (mdc_fall && state == ST_RD) begin
            mdio_oe_o <= (bitcnt >= TA_DRIVE) && (bitcnt <= DATA_LAST);
            mdio_o    <= (bitcnt >= DATA_FIRST) && (bitcnt <= DATA_LAST) && rd_shift[15];
            if (bitcnt >= DATA_FIRST) begin
                rd_shift <= {rd_shift[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_shift <= 16'h0000;
        end else if (mdc_rise && state == ST_WR && bitcnt >= DATA_FIRST) begin
            wr_shift <= wr_word;
        end
    end

    // control register, reserved bits kept at zero
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl <= CTRL_RESET;
        end else if (wr_fire && hdr[4:0] == REG_BYPASS_CTRL) begin
            ctrl <= wr_word & CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            bypass_4b5b_o          <= 1'b0;
            bypass_scrambler_o     <= 1'b0;
            bypass_nrzi_o          <= 1'b0;
            bypass_align_o         <= 1'b0;
            bw_corr_disable_o      <= 1'b0;
            far_end_fault_enable_o <= 1'b0;
        end else begin
            bypass_4b5b_o          <= ctrl[BIT_BYP_4B5B];
            bypass_scrambler_o     <= ctrl[BIT_BYP_SCRAM];
            bypass_nrzi_o          <= ctrl[BIT_BYP_NRZI];
            bypass_align_o         <= ctrl[BIT_BYP_ALIGN];
            bw_corr_disable_o      <= ctrl[BIT_BW_DISABLE];
            far_end_fault_enable_o <= ctrl[BIT_FEF_ENABLE];
        end
    end

    // latched-high flags, set wins over the read clear
    logic [NUM_FLAGS-1:0] flags;
    wire  [NUM_FLAGS-1:0] flag_ev = {false_carrier_i, end_of_stream_delimiter_err_i,
                                     rx_code_err_i, tx_code_err_i,
                                     lock_err_i, mlt3_err_i};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    flags[gi] <= FLAGS_RESET[gi];
                end else begin
                    flags[gi] <= (flags[gi] && !rd_status) || flag_ev[gi];
                end
            end
        end
    endgenerate

    wire fx_mode = sdp_s2 || sdn_s2;

    assign status_word = {4'h0,
                          fifo_error_i,
                          fx_mode,
                          locked_i,
                          link_pass_i,
                          remote_fault_i,
                          1'b0,
                          flags};

    // counters
    fpc_cnt_if cnt_bus [NUM_CNT] ();

    assign cnt_bus[CNT_RXERR].inc = rx_err_packet_i;
    assign cnt_bus[CNT_RXERR].clr = rd_rxerr;
    assign cnt_bus[CNT_FCAR].inc  = false_carrier_i;
    assign cnt_bus[CNT_FCAR].clr  = rd_fcar;
    assign cnt_bus[CNT_XRUN].inc  = fifo_xrun_i;
    assign cnt_bus[CNT_XRUN].clr  = rd_fcar;

    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            fpc_sat_counter #(
                .MAX (gi == CNT_RXERR ? RXERR_MAX : BYTE_MAX)
            ) u_cnt (
                .mclk_i  (mclk_i),
                .reset_i (reset_i),
                .port    (cnt_bus[gi])
            );
        end
    endgenerate

    wire [15:0] rxerr_val = cnt_bus[CNT_RXERR].value;
    wire [15:0] fcar_val  = cnt_bus[CNT_FCAR].value;
    wire [15:0] xrun_val  = cnt_bus[CNT_XRUN].value;

    assign read_word = (hdr_reg == REG_BYPASS_CTRL)  ? ctrl :
                       (hdr_reg == REG_STATUS_FLAGS) ? status_word :
                       (hdr_reg == REG_RXERR_COUNT)  ? rxerr_val :
                       {xrun_val[7:0], fcar_val[7:0]};

    // checks
    property p_ctrl_write;
        @(posedge mclk_i) disable iff (reset_i)
        (wr_fire && hdr[4:0] == REG_BYPASS_CTRL) |=> ##1
            (bypass_4b5b_o == $past(wr_word[BIT_BYP_4B5B], 2));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("4b5b bypass not taken");

    property p_scram_follow;
        @(posedge mclk_i) disable iff (reset_i)
        ##1 (bypass_scrambler_o == $past(ctrl[BIT_BYP_SCRAM]));
    endproperty
    a_scram_follow: assert property (p_scram_follow) else $error("scrambler bypass stale");

    property p_flag_set;
        @(posedge mclk_i) disable iff (reset_i)
        flag_ev[5] |=> flags[5];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("false carrier not latched");

    property p_flag_clear;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_status && flag_ev == 6'h00) |=> (flags == 6'h00);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");

    property p_flag_set_wins;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_status && flag_ev[0]) |=> flags[0];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("event lost at read");

    property p_flag_hold;
        @(posedge mclk_i) disable iff (reset_i)
        (flags[1] && !rd_status) |=> flags[1];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("lock flag dropped");

    property p_fx_low;
        @(posedge mclk_i) disable iff (reset_i)
        (!signal_detect_pair_p_i && !signal_detect_pair_n_i) [*3] |-> !status_word[10];
    endproperty
    a_fx_low: assert property (p_fx_low) else $error("fiber mode with no signal detect");

    c_read_done: cover property (@(posedge mclk_i) disable iff (reset_i) rd_release);
    c_write_done: cover property (@(posedge mclk_i) disable iff (reset_i) wr_fire);
    c_status_read: cover property (@(posedge mclk_i) disable iff (reset_i) rd_status && |flags);
endmodule

//--- tb/fpc_mgmt_host.sv
// management station model for the serial management pins
// assumes mdio_i is the resolved pin level with a pull-up
`timescale 1ns/100ps
module fpc_mgmt_host (
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o,
    input  wire logic mdio_i
);
    localparam realtime    HALF      = 62.5;
    localparam logic [1:0] OP_READ_H = 2'h2;
    // mdc stands low between frames
    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // one mdc period: data set while low, line sampled at the rise
    task automatic bit_cyc(input logic b, output logic s);
        mdio_o = b;
        #HALF;
        s     = mdio_i;
        mdc_o = 1'b1;
        #HALF;
        mdc_o = 1'b0;
    endtask
    // whole frame with its own preamble; rd is all ones when unanswered
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] reg_a, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [13:0] hdr;
        logic [17:0] tail;
        logic        s;
        hdr       = {2'h1, op, phy, reg_a};
        tail      = {2'h2, wd};
        mdio_oe_o = 1'b1;
        repeat (32) bit_cyc(1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], s);
        if (op == OP_READ_H) mdio_oe_o = 1'b0;
        for (int i = 17; i >= 0; i--) begin
            bit_cyc(tail[i], s);
            tail[i] = s;
        end
        rd        = tail[15:0];
        mdio_oe_o = 1'b0;
        #(2*HALF);
    endtask
endmodule

//--- tb/test_fpc_top.sv
// self-checking bench for the pcs control, status and counter bank
// assumes the host model drives management pins, events come from here
`timescale 1ns/100ps
module test_fpc_top;
    import fpc_pkg::*;
    localparam logic [4:0] PHY = 5'h05;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        mdc, h_o, h_oe, d_o, d_oe, line;
    logic        sd_p = 1'b0, sd_n = 1'b0, ferr = 1'b0, lck = 1'b0, lnk = 1'b0, rem = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [5:0]  byp;
    logic [15:0] v, v2;
    int          n_fail = 0, checks_done = 0, cycles = 0;
    // pull-up on the shared data pin
    assign line = d_oe ? d_o : (h_oe ? h_o : 1'b1);
    fpc_mgmt_host host (.mdc_o(mdc), .mdio_o(h_o), .mdio_oe_o(h_oe), .mdio_i(line));
    fpc_top DUT (
        .mclk_i(mclk), .reset_i(reset), .mdc_i(mdc), .mdio_i(line), .mdio_o(d_o),
        .mdio_oe_o(d_oe), .phy_addr_i(PHY), .signal_detect_pair_p_i(sd_p),
        .signal_detect_pair_n_i(sd_n), .fifo_error_i(ferr), .locked_i(lck),
        .link_pass_i(lnk), .remote_fault_i(rem), .false_carrier_i(ev[5]),
        .end_of_stream_delimiter_err_i(ev[4]), .rx_code_err_i(ev[3]),
        .tx_code_err_i(ev[2]), .lock_err_i(ev[1]), .mlt3_err_i(ev[0]),
        .rx_err_packet_i(ev[6]), .fifo_xrun_i(ev[7]), .bypass_4b5b_o(byp[5]),
        .bypass_scrambler_o(byp[4]), .bypass_nrzi_o(byp[3]), .bypass_align_o(byp[2]),
        .bw_corr_disable_o(byp[1]), .far_end_fault_enable_o(byp[0]));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            $display("mismatch cycle_limit expected below 80000 seen %0d", cycles);
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] r);
        host.frame(OP_READ, PHY, a, 16'h0000, r);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] w);
        logic [15:0] r;
        host.frame(OP_WRITE, PHY, a, w, r);
        repeat (8) @(negedge mclk);
    endtask
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(negedge mclk) ev[idx] = 1'b1;
            @(negedge mclk) ev[idx] = 1'b0;
        end
    endtask
    // reset values, wrong address and unmapped register get no answer
    task automatic t_reset();
        chk("bypass outputs", 16'h0000, {10'h000, byp});
        for (int a = 16; a < 20; a++) begin
            rd_reg(a[4:0], v);
            chk("reset value", 16'h0000, v);
        end
        host.frame(OP_READ, 5'h06, REG_STATUS_FLAGS, 16'h0000, v);
        chk("wrong phy", 16'hffff, v);
        rd_reg(5'h14, v);
        chk("unmapped", 16'hffff, v);
    endtask
    // each control bit alone drives its bypass output, reserved written zero
    // no mac traffic runs here, so transmit enable needs no driving
    task automatic t_ctrl();
        for (int b = 5; b <= 10; b++) begin
            wr_reg(REG_BYPASS_CTRL, 16'h0001 << b);
            chk("bypass outputs", 16'h0001 << (b - 5), {10'h000, byp});
            rd_reg(REG_BYPASS_CTRL, v);
            chk("ctrl readback", 16'h0001 << b, v & CTRL_WMASK);
        end
        wr_reg(REG_BYPASS_CTRL, 16'h07e0);
        chk("all bypass", 16'h003f, {10'h000, byp});
        wr_reg(REG_BYPASS_CTRL, 16'h0000);
        chk("bypass cleared", 16'h0000, {10'h000, byp});
    endtask
    // live status levels
    task automatic t_status();
        @(negedge mclk) {ferr, sd_p, sd_n, lck, lnk, rem} = 6'h35;
        repeat (8) @(negedge mclk);
        rd_reg(REG_STATUS_FLAGS, v);
        chk("live status a", 16'h0e80, v);
        @(negedge mclk) {ferr, sd_p, sd_n, lck, lnk, rem} = 6'h02;
        repeat (8) @(negedge mclk);
        rd_reg(REG_STATUS_FLAGS, v);
        chk("live status b", 16'h0100, v);
        @(negedge mclk) lnk = 1'b0;
    endtask
    // each latched flag sets on its pulse and clears once read
    task automatic t_flags();
        for (int i = 0; i < 6; i++) begin
            pulse(i, 1);
            rd_reg(REG_STATUS_FLAGS, v);
            chk("latched flag", 16'h0001 << i, v);
            rd_reg(REG_STATUS_FLAGS, v);
            chk("flag after read", 16'h0000, v);
        end
        rd_reg(REG_FCAR_FIFO, v);
        chk("false carrier one", 16'h0001, v);
    endtask
    // counting, clear on read and saturation
    task automatic t_count();
        pulse(7, 3);
        pulse(5, 2);
        pulse(6, 4);
        rd_reg(REG_FCAR_FIFO, v);
        chk("byte counters", 16'h0302, v);
        rd_reg(REG_RXERR_COUNT, v);
        chk("rx error count", 16'h0004, v);
        rd_reg(REG_FCAR_FIFO, v);
        chk("byte counters cleared", 16'h0000, v);
        rd_reg(REG_RXERR_COUNT, v);
        chk("rx error cleared", 16'h0000, v);
        pulse(6, 300);
        pulse(5, 260);
        pulse(7, 256);
        rd_reg(REG_RXERR_COUNT, v);
        chk("rx error saturated", 16'h00ff, v);
        rd_reg(REG_FCAR_FIFO, v);
        chk("byte counters saturated", 16'hffff, v);
        rd_reg(REG_STATUS_FLAGS, v);
    endtask
    // 200 back-to-back events straddle the clearing read; none may be lost
    task automatic t_race();
        fork
            rd_reg(REG_RXERR_COUNT, v);
            begin
                #4950;
                @(negedge mclk) ev[6] = 1'b1;
                repeat (200) @(negedge mclk);
                ev[6] = 1'b0;
            end
        join
        rd_reg(REG_RXERR_COUNT, v2);
        chk("events around clear", 16'h00c8, v + v2);
        fork
            rd_reg(REG_STATUS_FLAGS, v);
            begin
                #4950;
                @(negedge mclk) ev[0] = 1'b1;
                repeat (200) @(negedge mclk);
                ev[0] = 1'b0;
            end
        join
        chk("flag before clear", 16'h0001, v);
        rd_reg(REG_STATUS_FLAGS, v);
        chk("flag set at clear", 16'h0001, v);
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
        t_reset();
        t_ctrl();
        t_status();
        t_flags();
        t_count();
        t_race();
        close_out();
    end
endmodule
